// >>> hdl/psc_counters.sv
// Packet status flags, collision, byte and gap counters of a repeater
//
// Contract
// - Timer bits 9:8 in error byte bits 1:0
// - Jabber flag at bit 2
// - Elastic buffer error flag at bit 3
// - Decoder lock loss flag at bit 4
// - Missing delimiter flag at bit 5, selects mode
// - Collisions never suppress missing delimiter flag
// - Late collision flag at bit 6
// - Short event flag at bit 7
// - Collision timer counts bits, freezes at collision
// - With delimiter, count post-delimiter bytes, 16 bits
// - Without delimiter, count from preamble, max 127
// - Gap timer counts bits while not transmitting
// - Gap timer saturates and holds at 255
// - Collision flag at bit 5 of second byte
// - Seven status bytes sent per packet
`timescale 1ns/10ps
`default_nettype none
`include "psc_map.svh"

module psc_counters #(
    parameter int COLT_W = `PSC_COLT_WIDTH,
    parameter int RBY_W  = `PSC_RBY_WIDTH
) (
    // Clock, reset, enable
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    input  wire logic                 clk_en,
    // Network timing
    input  wire logic                 bit_tick,
    input  wire logic                 byte_tick,
    // Packet activity
    input  wire logic                 repeat_active,
    input  wire logic                 tx_active,
    input  wire logic                 delimiter_seen,
    input  wire logic                 collision,
    input  wire psc_pkg::psc_events_t events,
    // Earlier status bytes from the port logic
    input  wire logic [7:0]           status_zero,
    input  wire logic [7:0]           status_one,
    // Management side byte read
    input  wire logic                 rd_en,
    input  wire logic [2:0]           rd_idx,
    output logic      [7:0]           rd_data,
    output logic                      rd_valid,
    output logic                      field_ready
);

    // ****************************************
    // State and counters
    // ****************************************
    psc_pkg::psc_state_t state_reg;      // Packet tracking state
    psc_pkg::psc_state_t state_next;     // Its next value
    logic              active_d_reg;     // Previous repeat activity
    logic              tx_d_reg;         // Previous transmit activity
    logic              pkt_start;        // First cycle of repetition
    logic              pkt_end;          // Repetition just ended
    logic              tx_start;         // Transmission just began
    logic [COLT_W-1:0] colt_reg;         // Collision bit timer
    logic              col_flag_reg;     // Collision seen in packet
    logic [RBY_W-1:0]  rby_reg;          // Repeat byte counter
    logic              delim_reg;        // Delimiter seen in packet
    logic [7:0]        gap_reg;          // Running gap timer
    logic [7:0]        gap_cap_reg;      // Gap before this packet
    logic [4:0]        flags_reg;        // Sticky error events
    logic              missing_delim;    // No delimiter in packet
    psc_pkg::psc_field_t field;          // Assembled status field
    logic              store_en;         // Load snapshot store

    assign pkt_start = repeat_active && !active_d_reg;
    assign pkt_end   = !repeat_active && active_d_reg;
    assign tx_start  = tx_active && !tx_d_reg;
    assign store_en  = (state_reg == psc_pkg::PSC_STORE);

    // Missing delimiter is judged on delimiters alone, collisions ignored
    assign missing_delim = !delim_reg;

    // ****************************************
    // Edge history
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            active_d_reg <= 1'b0;
            tx_d_reg     <= 1'b0;
        end else if (clk_en) begin
            active_d_reg <= repeat_active;
            tx_d_reg     <= tx_active;
        end
    end

    // ****************************************
    // Packet tracking state machine
    // ****************************************
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            psc_pkg::PSC_IDLE: begin
                // Wait for repetition to begin
                if (pkt_start) begin
                    state_next = psc_pkg::PSC_REPEAT;
                end
            end
            psc_pkg::PSC_REPEAT: begin
                // Packet ends, take the snapshot next
                if (pkt_end) begin
                    state_next = psc_pkg::PSC_STORE;
                end
            end
            psc_pkg::PSC_STORE: begin
                state_next = pkt_start ? psc_pkg::PSC_REPEAT : psc_pkg::PSC_IDLE;
            end
            default: begin
                state_next = psc_pkg::PSC_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= psc_pkg::PSC_IDLE;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // Collision bit timer and collision flag
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            colt_reg     <= '0;
            col_flag_reg <= 1'b0;
        end else if (clk_en) begin
            if (pkt_start) begin
                // Fresh packet, collision in the first cycle still counts
                colt_reg     <= '0;
                col_flag_reg <= collision;
            end else if (repeat_active) begin
                if (collision) begin
                    col_flag_reg <= 1'b1;
                end
                // Advance per bit until the first collision, then hold
                if (bit_tick && !col_flag_reg && !collision && !(&colt_reg)) begin
                    colt_reg <= colt_reg + 1'b1;
                end
            end
        end
    end

    // ****************************************
    // Repeat byte counter
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rby_reg   <= '0;
            delim_reg <= 1'b0;
        end else if (clk_en) begin
            if (pkt_start) begin
                rby_reg   <= '0;
                delim_reg <= 1'b0;
            end else if (repeat_active) begin
                if (delimiter_seen && !delim_reg) begin
                    // Restart counting after the delimiter
                    delim_reg <= 1'b1;
                    rby_reg   <= '0;
                end else if (byte_tick) begin
                    if (delim_reg) begin
                        rby_reg <= rby_reg + 1'b1;
                    end else if (rby_reg < RBY_W'(`PSC_RBY_SHORT_MAX)) begin
                        rby_reg <= rby_reg + 1'b1;
                    end
                end
            end
        end
    end

    // ****************************************
    // Inter-frame gap timer
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_reg     <= '0;
            gap_cap_reg <= '0;
        end else if (clk_en) begin
            if (tx_start) begin
                // Keep the gap that preceded this transmission
                gap_cap_reg <= gap_reg;
                gap_reg     <= '0;
            end else if (!tx_active && bit_tick && gap_reg != `PSC_GAP_MAX) begin
                gap_reg <= gap_reg + 8'h01;
            end
        end
    end

    // ****************************************
    // Sticky packet error events, set wins over clear
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_reg <= '0;
        end else if (clk_en) begin
            if (pkt_start) begin
                flags_reg <= events;
            end else if (repeat_active) begin
                flags_reg <= flags_reg | events;
            end
        end
    end

    // ****************************************
    // Status field assembly
    // ****************************************
    always_comb begin
        field = '0;
        field.status_zero  = status_zero;
        field.status_one   = status_one;
        field.status_one[`PSC_S1_COL_BIT] = col_flag_reg;
        field.packet_error_flags[`PSC_ERR_CT8_BIT]     = colt_reg[8];
        field.packet_error_flags[`PSC_ERR_CT9_BIT]     = colt_reg[9];
        field.packet_error_flags[`PSC_ERR_JAB_BIT]     = flags_reg[0];
        field.packet_error_flags[`PSC_ERR_ELB_BIT]     = flags_reg[1];
        field.packet_error_flags[`PSC_ERR_LOCK_BIT]    = flags_reg[2];
        field.packet_error_flags[`PSC_ERR_NODELIM_BIT] = missing_delim;
        field.packet_error_flags[`PSC_ERR_LATECOL_BIT] = flags_reg[3];
        field.packet_error_flags[`PSC_ERR_SHORT_BIT]   = flags_reg[4];
        field.collision_timer_low = colt_reg[7:0];
        field.repeat_bytes_low    = rby_reg[7:0];
        field.repeat_bytes_high   = rby_reg[15:8];
        field.gap_bit_timer       = gap_cap_reg;
    end

    // ****************************************
    // Field ready, set at store, cleared by last byte read
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            field_ready <= 1'b0;
        end else if (clk_en) begin
            if (store_en) begin
                field_ready <= 1'b1;
            end else if (rd_en && rd_idx == `PSC_IDX_LAST) begin
                field_ready <= 1'b0;
            end
        end
    end

    // Snapshot store for the seven bytes
    psc_status_mem #(
        .DEPTH    (`PSC_FIELD_BYTES)
    ) u_mem (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .wr_en    (store_en),
        .wr_field (field),
        .rd_en    (rd_en),
        .rd_idx   (rd_idx),
        .rd_data  (rd_data),
        .rd_valid (rd_valid)
    );

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_timer_freeze: assert property (clk_en && repeat_active && !pkt_start && col_flag_reg |=>
        $stable(colt_reg)) else $error("Collision timer moved after collision");
    a_timer_count: assert property (clk_en && repeat_active && !pkt_start && bit_tick && !collision
        && !col_flag_reg && colt_reg < 10'h3ff |=> colt_reg == $past(colt_reg) + 10'h001)
        else $error("Collision timer missed a bit");
    a_gap_saturate: assert property (gap_reg == `PSC_GAP_MAX && !tx_start |=>
        gap_reg == `PSC_GAP_MAX) else $error("Gap timer left saturation");
    a_gap_clear: assert property (clk_en && tx_start |=> gap_reg == 8'h00)
        else $error("Gap timer not cleared at transmission start");
    a_gap_hold_tx: assert property (clk_en && tx_active && tx_d_reg |=> $stable(gap_reg))
        else $error("Gap timer counted during transmission");
    a_short_limit: assert property (!delim_reg |-> rby_reg <= `PSC_RBY_SHORT_MAX)
        else $error("Short byte count above limit");
    a_delim_restart: assert property (clk_en && repeat_active && !pkt_start && delimiter_seen
        && !delim_reg |=> rby_reg == '0 && delim_reg) else $error("Byte count not restarted at delimiter");
    a_err_byte_map: assert property (field.packet_error_flags[1:0] == colt_reg[9:8]
        && field.packet_error_flags[`PSC_ERR_NODELIM_BIT] == !delim_reg)
        else $error("Error byte layout wrong");
    a_event_sticky: assert property (clk_en && repeat_active && !pkt_start && events.jabber
        |=> ##[0:2] (flags_reg[0] || pkt_start)) else $error("Jabber event lost");
    a_store_once: assert property (clk_en && pkt_end && state_reg == psc_pkg::PSC_REPEAT
        |=> store_en ##1 field_ready) else $error("Field not stored after packet");
    a_collision_flag: assert property (clk_en && repeat_active && collision |=> col_flag_reg)
        else $error("Collision flag not set");

    c_collided_packet: cover property (col_flag_reg && pkt_end);
    c_nodelim_packet: cover property (!delim_reg && rby_reg == `PSC_RBY_SHORT_MAX && pkt_end);
    c_gap_saturated: cover property (gap_reg == `PSC_GAP_MAX ##1 tx_start);

endmodule
`default_nettype wire

// >>> hdl/psc_map.svh
// Bit positions, widths and limits of the packet status field
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH

// ****************************************
// Error flag byte, bit positions
// ****************************************
`define PSC_ERR_CT8_BIT      0
`define PSC_ERR_CT9_BIT      1
`define PSC_ERR_JAB_BIT      2
`define PSC_ERR_ELB_BIT      3
`define PSC_ERR_LOCK_BIT     4
`define PSC_ERR_NODELIM_BIT  5
`define PSC_ERR_LATECOL_BIT  6
`define PSC_ERR_SHORT_BIT    7

// ****************************************
// Second status byte, collision flag
// ****************************************
`define PSC_S1_COL_BIT       5

// ****************************************
// Field layout and counter limits
// ****************************************
`define PSC_FIELD_BYTES      7
`define PSC_IDX_ERR          3'h2
`define PSC_IDX_LAST         3'h6
`define PSC_COLT_WIDTH       10
`define PSC_RBY_WIDTH        16
`define PSC_RBY_SHORT_MAX    16'h007f
`define PSC_GAP_MAX          8'hff
`define PSC_BYTE_RESET       8'h00

`endif

// >>> hdl/psc_pkg.sv
// Types shared by the packet status counter files
package psc_pkg;

    // Seven status bytes in transfer order, byte 0 in the low bits
    typedef struct packed {
        logic [7:0] gap_bit_timer;
        logic [7:0] repeat_bytes_high;
        logic [7:0] repeat_bytes_low;
        logic [7:0] collision_timer_low;
        logic [7:0] packet_error_flags;
        logic [7:0] status_one;
        logic [7:0] status_zero;
    } psc_field_t;

    // Per-packet event inputs
    typedef struct packed {
        logic short_event;
        logic late_collision;
        logic lock_loss;
        logic elastic_error;
        logic jabber;
    } psc_events_t;

    // Packet tracking states
    typedef enum logic [1:0] {
        PSC_IDLE   = 2'b00,
        PSC_REPEAT = 2'b01,
        PSC_STORE  = 2'b10
    } psc_state_t;

endpackage

// >>> hdl/psc_status_mem.sv
// Snapshot store for the seven status bytes with registered read
`timescale 1ns/10ps
`default_nettype none
`include "psc_map.svh"

module psc_status_mem #(
    parameter int DEPTH = `PSC_FIELD_BYTES
) (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic              clk_en,
    // Write side, whole field at once
    input  wire logic              wr_en,
    input  wire psc_pkg::psc_field_t wr_field,
    // Read side
    input  wire logic              rd_en,
    input  wire logic [2:0]        rd_idx,
    output logic      [7:0]        rd_data,
    output logic                   rd_valid
);

    // ****************************************
    // Storage
    // ****************************************
    logic [7:0] mem_reg [DEPTH];         // Stored bytes
    logic [DEPTH*8-1:0] wr_flat;         // Field as flat bytes

    assign wr_flat = wr_field;

    // One write port per entry, all loaded together
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_entry
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    mem_reg[g] <= `PSC_BYTE_RESET;
                end else if (clk_en && wr_en) begin
                    mem_reg[g] <= wr_flat[g*8 +: 8];
                end
            end
        end
    endgenerate

    // ****************************************
    // Registered read
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data  <= `PSC_BYTE_RESET;
            rd_valid <= 1'b0;
        end else if (clk_en) begin
            rd_valid <= rd_en;
            // Out of range index reads as zero
            if (rd_en) begin
                rd_data <= (32'(rd_idx) < DEPTH) ? mem_reg[rd_idx] : `PSC_BYTE_RESET;
            end
        end
    end

endmodule
`default_nettype wire

// >>> verification/psc_counters_tb.sv
// Self-checking bench for the packet status counters
`timescale 1ns/10ps
`default_nettype none

module psc_counters_tb;
    // ****************************************
    // Signals
    // ****************************************
    logic                 core_clk;        // 50 MHz clock
    logic                 rst_n;           // Reset, active low
    logic                 clk_en;          // Clock enable
    logic                 bit_tick;        // Bit time pulse
    logic                 byte_tick;       // Byte pulse
    logic                 repeat_active;   // Packet being repeated
    logic                 tx_active;       // Repeater transmitting
    logic                 delimiter_seen;  // Frame delimiter pulse
    logic                 collision;       // Collision pulse
    psc_pkg::psc_events_t events;          // Event pulses
    logic [7:0]           status_zero;     // Byte 0 input
    logic [7:0]           status_one;      // Byte 1 input
    logic                 rd_en;           // Read strobe from model
    logic [2:0]           rd_idx;          // Read index from model
    logic [7:0]           rd_data;         // Read byte
    logic                 rd_valid;        // Read answer pulse
    logic                 field_ready;     // Field stored
    logic                 go;              // Start model read
    logic [7:0]           fb [0:6];        // Bytes seen by model
    logic [3:0]           got_cnt;         // Bytes collected
    int                   fail_count;      // Mismatches
    int                   checked;         // Comparisons made
    int                   cycles;          // Timeout counter

    // ****************************************
    // Instances
    // ****************************************
    psc_counters u_psc_counters (
        .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
        .bit_tick(bit_tick), .byte_tick(byte_tick),
        .repeat_active(repeat_active), .tx_active(tx_active),
        .delimiter_seen(delimiter_seen), .collision(collision), .events(events),
        .status_zero(status_zero), .status_one(status_one),
        .rd_en(rd_en), .rd_idx(rd_idx), .rd_data(rd_data),
        .rd_valid(rd_valid), .field_ready(field_ready)
    );

    psc_mgmt_model u_psc_mgmt_model (
        .core_clk(core_clk), .rst_n(rst_n), .go(go),
        .rd_en(rd_en), .rd_idx(rd_idx), .rd_data(rd_data),
        .rd_valid(rd_valid), .field_bytes(fb), .got_cnt(got_cnt)
    );

    // ****************************************
    // Clock and timeout
    // ****************************************
    // Half period of 10 ns
    initial core_clk = 1'b0;
    always #10 core_clk = ~core_clk;

    // Cuts a hang short
    initial cycles = 0;
    always @(posedge core_clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            fail_count = fail_count + 1;
            summarize();
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    // Compares one value and counts it
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Gives n bit or byte pulses, two cycles apart
    task automatic ticks(input int n, input bit is_byte);
        repeat (n) begin
            @(negedge core_clk);
            if (is_byte) byte_tick = 1'b1;
            else bit_tick = 1'b1;
            @(negedge core_clk);
            byte_tick = 1'b0;
            bit_tick  = 1'b0;
        end
    endtask

    // One-cycle pulse on the event inputs
    task automatic ev_pulse(input logic [4:0] v);
        @(negedge core_clk);
        events = v;
        @(negedge core_clk);
        events = 5'h00;
    endtask

    // Ends a packet, waits for the field and reads it through the model
    task automatic finish_pkt();
        int n;
        @(negedge core_clk);
        repeat_active = 1'b0;
        n = 0;
        while (field_ready !== 1'b1 && n < 20) begin
            @(negedge core_clk);
            n++;
        end
        chk("field_ready", {7'h00, field_ready}, 8'h01);
        go = 1'b1;
        @(negedge core_clk);
        go = 1'b0;
        n = 0;
        while (got_cnt !== 4'h7 && n < 30) begin
            @(negedge core_clk);
            n++;
        end
        chk("got_cnt", {4'h0, got_cnt}, 8'h07);
        chk("ready_clear", {7'h00, field_ready}, 8'h00);
    endtask

    // Prints the counts and the verdict, then stops
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        fail_count = 0;
        checked = 0;
        rst_n = 1'b0;
        clk_en = 1'b1;
        {bit_tick, byte_tick, repeat_active, tx_active} = 4'h0;
        {delimiter_seen, collision, go} = 3'h0;
        events = 5'h00;
        status_zero = 8'ha5;
        status_one = 8'h0f;
        repeat (5) @(negedge core_clk);
        rst_n = 1'b1;
        // Packet with delimiter and an early collision; gap of 10 bits
        // Bit ticks while the clock enable is low must leave the gap alone
        clk_en = 1'b0;
        ticks(3, 1'b0);
        clk_en = 1'b1;
        ticks(10, 1'b0);
        @(negedge core_clk);
        repeat_active = 1'b1;
        tx_active = 1'b1;
        @(negedge core_clk);
        ticks(5, 1'b0);
        collision = 1'b1;
        @(negedge core_clk);
        collision = 1'b0;
        ticks(3, 1'b0);
        ev_pulse(5'b00011);
        ticks(3, 1'b1);
        delimiter_seen = 1'b1;
        @(negedge core_clk);
        delimiter_seen = 1'b0;
        ticks(20, 1'b1);
        finish_pkt();
        chk("status_zero", fb[0], 8'ha5);
        chk("status_one", fb[1], 8'h2f);
        chk("error_flags", fb[2], 8'h0c);
        chk("col_timer", fb[3], 8'h05);
        chk("bytes_low", fb[4], 8'h14);
        chk("bytes_high", fb[5], 8'h00);
        chk("gap", fb[6], 8'h0a);
        // Packet without delimiter, late collision, long gap
        tx_active = 1'b0;
        status_one = 8'h1f;
        @(negedge core_clk);
        repeat_active = 1'b1;
        @(negedge core_clk);
        ticks(770, 1'b0);
        collision = 1'b1;
        @(negedge core_clk);
        collision = 1'b0;
        ev_pulse(5'b11100);
        ticks(130, 1'b1);
        tx_active = 1'b1;
        @(negedge core_clk);
        finish_pkt();
        chk("status_one", fb[1], 8'h3f);
        chk("error_flags", fb[2], 8'hf3);
        chk("col_timer", fb[3], 8'h02);
        chk("bytes_low", fb[4], 8'h7f);
        chk("bytes_high", fb[5], 8'h00);
        chk("gap", fb[6], 8'hff);
        summarize();
    end
endmodule
`default_nettype wire

// >>> verification/psc_mgmt_model.sv
// Management side reader that collects the seven status bytes of a field
`timescale 1ns/10ps
`default_nettype none

module psc_mgmt_model (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // Start request from the bench
    input  wire logic       go,
    // Byte read port of the block
    output logic            rd_en,
    output logic [2:0]      rd_idx,
    input  wire logic [7:0] rd_data,
    input  wire logic       rd_valid,
    // Collected bytes
    output logic [7:0]      field_bytes [0:6],
    output logic [3:0]      got_cnt
);
    // ****************************************
    // Request side
    // ****************************************
    // Issues one read per cycle for bytes 0 to 6, back to back
    initial begin
        rd_en  = 1'b0;
        rd_idx = 3'h7;
        forever begin
            @(posedge go);
            for (int i = 0; i < 7; i++) begin
                @(negedge core_clk);
                rd_en  = 1'b1;
                rd_idx = i[2:0];
            end
            @(negedge core_clk);
            rd_en  = 1'b0;
            // Index no longer qualified, so show another value
            rd_idx = ~rd_idx;
        end
    end

    // ****************************************
    // Answer side
    // ****************************************
    // Stores each returned byte in order; software reads all bytes so the
    // collision flag can be weighed before the timer and delimiter flag
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            got_cnt <= 4'h0;
        end else if (go) begin
            got_cnt <= 4'h0;
        end else if (rd_valid && got_cnt < 4'h7) begin
            field_bytes[got_cnt[2:0]] <= rd_data;
            got_cnt                   <= got_cnt + 4'h1;
        end
    end
endmodule
`default_nettype wire
